// *** core/swl_pkg.sv ***
// Package for the sweep and list sequencer: constants and types
package swl_pkg;
    localparam int FREQ_W        = 48;
    localparam int LEVEL_W       = 16;
    localparam int DWELL_W       = 32;
    localparam int LOG_FRAC_W    = 16;
    localparam int LIST_DEPTH    = 16;
    localparam logic [DWELL_W-1:0] DWELL_RESET = 32'h0000_0001;
    localparam int SYNC_STAGES   = 2;
    localparam int CLK_PERIOD_PS = 4000;

    typedef enum logic [1:0] {
        SWL_AUTO, SWL_SINGLE, SWL_STEP, SWL_EXT_START_STOP
    } swl_mode_t;

    typedef enum logic [1:0] {
        SWL_OFF, SWL_FREQ_SWEEP, SWL_LEVEL_SWEEP, SWL_LIST
    } swl_func_t;
endpackage : swl_pkg

// *** core/swl_trig_if.sv ***
// Interface carrying the qualified trigger between sequencer and edge unit
`timescale 1ns/10ps
`default_nettype none
interface swl_trig_if;
    logic extTrig;
    logic slopeFalling;
    logic trigPulse;
    modport edge_unit (input extTrig, input slopeFalling, output trigPulse);
    modport seq (output extTrig, output slopeFalling, input trigPulse);
endinterface : swl_trig_if
`default_nettype wire

// *** core/swl_trig_edge.sv ***
// Trigger synchroniser and selectable edge detector
`timescale 1ns/10ps
`default_nettype none
module swl_trig_edge
    import swl_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic reset,
    swl_trig_if.edge_unit trig
);
    logic [SYNC_STAGES-1:0] syncChain_reg;
    logic                   lastLevel_reg;
    logic                   pulse_reg;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            syncChain_reg <= '0;
        end else begin
            syncChain_reg <= {syncChain_reg[SYNC_STAGES-2:0], trig.extTrig};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lastLevel_reg <= 1'b0;
            pulse_reg     <= 1'b0;
        end else begin
            lastLevel_reg <= syncChain_reg[SYNC_STAGES-1];
            pulse_reg     <= trig.slopeFalling
                ? (lastLevel_reg & ~syncChain_reg[SYNC_STAGES-1])
                : (~lastLevel_reg & syncChain_reg[SYNC_STAGES-1]);
        end
    end

    assign trig.trigPulse = pulse_reg;
endmodule : swl_trig_edge
`default_nettype wire

// *** core/swl_sequencer.sv ***
// Sweep and list sequencer: frequency, level and list stepping
`timescale 1ns/10ps
`default_nettype none
module swl_sequencer
    import swl_pkg::*;
#(
    parameter int LIST_N = LIST_DEPTH
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire swl_pkg::swl_func_t       funcReq,
    input  wire logic                     funcReqValid,
    input  wire swl_pkg::swl_mode_t       sweepMode,
    input  wire swl_pkg::swl_mode_t       listMode,
    input  wire logic                     shapeTriangle,
    input  wire logic                     retraceEn,
    input  wire logic                     spacingLog,
    input  wire logic                     rangeByCenter,
    input  wire logic [FREQ_W-1:0]        freqStart,
    input  wire logic [FREQ_W-1:0]        freqStop,
    input  wire logic [FREQ_W-1:0]        freqCenter,
    input  wire logic [FREQ_W-1:0]        freqSpan,
    input  wire logic [FREQ_W-1:0]        freqStepLin,
    input  wire logic [LOG_FRAC_W-1:0]    freqStepLogFrac,
    input  wire logic signed [LEVEL_W-1:0] levelStart,
    input  wire logic signed [LEVEL_W-1:0] levelStop,
    input  wire logic [LEVEL_W-1:0]       levelStepDb,
    input  wire logic [DWELL_W-1:0]       sweepDwell,
    input  wire logic                     dwellFromList,
    input  wire logic [DWELL_W-1:0]       globalDwell,
    input  wire logic                     entryWrEn,
    input  wire logic [$clog2(LIST_N)-1:0] entryWrIdx,
    input  wire logic [FREQ_W-1:0]        entryWrFreq,
    input  wire logic [LEVEL_W-1:0]       entryWrLevel,
    input  wire logic [DWELL_W-1:0]       entryWrDwell,
    input  wire logic                     indexWrEn,
    input  wire logic [$clog2(LIST_N)-1:0] indexWrVal,
    input  wire logic                     sweepResetCmd,
    input  wire logic                     listResetCmd,
    input  wire logic                     executeCmd,
    input  wire logic                     extTrigIn,
    input  wire logic                     trigSlopeFalling,
    output swl_pkg::swl_func_t            activeFunc,
    output logic [FREQ_W-1:0]             curFreq,
    output logic [LEVEL_W-1:0]            curLevel,
    output logic [$clog2(LIST_N)-1:0]     curIndex,
    output logic                          running,
    output logic [FREQ_W-1:0]             effStart,
    output logic [FREQ_W-1:0]             effStop
);
    localparam int IDX_W = $clog2(LIST_N);

    // Elaboration guard: index and wrap logic need at least two entries
    if (LIST_N < 2 || LIST_N > 1024) begin : gListNCheck
        $error("LIST_N out of range");
    end

    swl_trig_if trigBus ();
    assign trigBus.extTrig      = extTrigIn;
    assign trigBus.slopeFalling = trigSlopeFalling;

    swl_trig_edge uEdge (
        .core_clk (core_clk),
        .reset    (reset),
        .trig     (trigBus.edge_unit)
    );

    swl_func_t              func_reg;
    logic [FREQ_W-1:0]      freq_reg;
    logic signed [LEVEL_W-1:0] level_reg;
    logic [IDX_W-1:0]       idx_reg;
    logic                   run_reg;
    logic                   down_reg;
    logic [DWELL_W-1:0]     dwellCnt_reg;
    logic                   modeWasAuto_reg;
    logic [FREQ_W-1:0]      listFreq  [LIST_N];
    logic [LEVEL_W-1:0]     listLevel [LIST_N];
    logic [DWELL_W-1:0]     listDwell [LIST_N];

    logic [FREQ_W-1:0] halfSpan;
    assign halfSpan = freqSpan >> 1;
    assign effStart = rangeByCenter ? freqCenter - halfSpan : freqStart;
    assign effStop  = rangeByCenter ? freqCenter + halfSpan : freqStop;

    logic trig;
    logic isSweep;
    logic isList;
    swl_mode_t mode;
    assign isSweep = (func_reg == SWL_FREQ_SWEEP)
                   || (func_reg == SWL_LEVEL_SWEEP);
    assign isList  = func_reg == SWL_LIST;
    assign mode    = isList ? listMode : sweepMode;
    // execute acts as trigger in single mode
    assign trig = trigBus.trigPulse
        | (executeCmd & (mode == SWL_SINGLE));

    // Dwell length in force for the present step
    logic [DWELL_W-1:0] dwellNow;
    always_comb begin
        dwellNow = sweepDwell;
        if (isList) begin
            dwellNow = dwellFromList ? listDwell[idx_reg] : globalDwell;
        end
        if (dwellNow == '0)
            dwellNow = DWELL_RESET;
    end

    logic dwellDone;
    // step advances after a full dwell
    assign dwellDone = run_reg && (dwellCnt_reg + 1'b1 >= dwellNow);

    // Next frequency: wider intermediate keeps the product exact
    logic [FREQ_W+LOG_FRAC_W-1:0] logProd;
    logic [FREQ_W-1:0] freqInc;
    logic [FREQ_W:0]   freqUp;
    logic [FREQ_W:0]   freqDn;
    assign logProd = freq_reg * freqStepLogFrac;
    // linear hertz or fraction of present
    assign freqInc = spacingLog
        ? logProd[FREQ_W+LOG_FRAC_W-1:LOG_FRAC_W] : freqStepLin;
    assign freqUp = {1'b0, freq_reg} + {1'b0, freqInc};
    assign freqDn = {1'b0, freq_reg} - {1'b0, freqInc};

    // one fixed dB step for level
    logic signed [LEVEL_W:0] levUp;
    logic signed [LEVEL_W:0] levDn;
    assign levUp = level_reg + $signed({1'b0, levelStepDb});
    assign levDn = level_reg - $signed({1'b0, levelStepDb});

    logic atEnd;
    always_comb begin
        atEnd = 1'b0;
        if (func_reg == SWL_FREQ_SWEEP) begin
            if (down_reg)
                atEnd = freqDn[FREQ_W] || freqDn[FREQ_W-1:0] < effStart
                        || freqInc == '0;
            else
                atEnd = freqUp > {1'b0, effStop} || freqInc == '0;
        end else if (func_reg == SWL_LEVEL_SWEEP) begin
            if (down_reg)
                atEnd = levDn < levelStart;
            else
                atEnd = levUp > levelStop;
        end else if (isList) begin
            atEnd = idx_reg == IDX_W'(LIST_N - 1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            func_reg <= SWL_OFF;
        end else if (funcReqValid) begin
            func_reg <= funcReq;
        end
    end

    logic startFunc;
    assign startFunc = funcReqValid && (funcReq != func_reg);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            modeWasAuto_reg <= 1'b0;
        end else begin
            modeWasAuto_reg <= listMode == SWL_AUTO;
        end
    end

    logic listAutoEntry;
    assign listAutoEntry = isList && listMode == SWL_AUTO
                         && !modeWasAuto_reg;

    // Run state: auto runs free, single runs one pass
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            run_reg <= 1'b0;
        end else if (startFunc || func_reg == SWL_OFF) begin
            run_reg <= 1'b0;
        end else if (isList && listResetCmd) begin
            run_reg <= 1'b0;
        end else if (isSweep && sweepResetCmd) begin
            run_reg <= 1'b0;
        end else begin
            case (mode)
                SWL_AUTO: begin
                    run_reg <= 1'b1;
                end
                SWL_SINGLE: begin
                    if (trig)
                        run_reg <= 1'b1;
                    else if (dwellDone && atEnd && !down_reg
                             && !(shapeTriangle && isSweep))
                        run_reg <= 1'b0;
                    else if (dwellDone && atEnd && down_reg)
                        run_reg <= 1'b0;
                end
                SWL_EXT_START_STOP: begin
                    if (trigBus.trigPulse)
                        run_reg <= ~run_reg;
                end
                default: begin
                    run_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dwellCnt_reg <= '0;
        end else if (!run_reg || dwellDone) begin
            dwellCnt_reg <= '0;
        end else begin
            dwellCnt_reg <= dwellCnt_reg + 1'b1;
        end
    end

    // Restart of a sweep or pass at its start value
    logic restart;
    assign restart = startFunc || (isSweep && sweepResetCmd)
        || (!run_reg && trig && mode == SWL_SINGLE)
        || (!run_reg && isSweep && mode == SWL_AUTO);

    // Frequency and level stepping
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            freq_reg  <= '0;
            level_reg <= '0;
            down_reg  <= 1'b0;
        end else if (restart) begin
            freq_reg  <= effStart;
            level_reg <= levelStart;
            down_reg  <= 1'b0;
        end else if (isSweep && mode == SWL_STEP && trig) begin
            if (func_reg == SWL_FREQ_SWEEP)
                freq_reg <= atEnd ? effStart : freqUp[FREQ_W-1:0];
            else
                level_reg <= atEnd ? levelStart : levUp[LEVEL_W-1:0];
        end else if (isSweep && dwellDone) begin
            if (!atEnd && func_reg == SWL_FREQ_SWEEP) begin
                freq_reg  <= down_reg ? freqDn[FREQ_W-1:0]
                                      : freqUp[FREQ_W-1:0];
            end else if (!atEnd) begin
                // Level sweep leaves the frequency alone
                level_reg <= down_reg ? levDn[LEVEL_W-1:0]
                                      : levUp[LEVEL_W-1:0];
            end else if (shapeTriangle && !down_reg) begin
                down_reg <= 1'b1;
            end else if (mode != SWL_SINGLE || retraceEn) begin
                freq_reg  <= effStart;
                level_reg <= levelStart;
                down_reg  <= 1'b0;
            end
        end
    end

    // List index stepping
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            idx_reg <= '0;
        end else if (startFunc || listAutoEntry
                     || (isList && listResetCmd)) begin
            idx_reg <= '0;
        end else if (isList && mode == SWL_STEP) begin
            if (indexWrEn)
                idx_reg <= indexWrVal;
            else if (trig)
                idx_reg <= atEnd ? '0 : idx_reg + 1'b1;
        end else if (isList && !run_reg && trig && mode == SWL_SINGLE) begin
            idx_reg <= '0;
        end else if (isList && dwellDone) begin
            if (!atEnd)
                idx_reg <= idx_reg + 1'b1;
            else if (mode != SWL_SINGLE)
                idx_reg <= '0;
        end
    end

    // List table storage
    always_ff @(posedge core_clk) begin
        if (entryWrEn) begin
            listFreq[entryWrIdx]  <= entryWrFreq;
            listLevel[entryWrIdx] <= entryWrLevel;
            listDwell[entryWrIdx] <= entryWrDwell;
        end
    end

    assign activeFunc = func_reg;
    assign running    = run_reg;
    assign curIndex   = idx_reg;
    assign curFreq    = isList ? listFreq[idx_reg] : freq_reg;
    assign curLevel   = isList ? listLevel[idx_reg] : level_reg;
endmodule : swl_sequencer
`default_nettype wire

// *** verif/swl_trig_source.sv ***
// Behavioural source for the external trigger pin
`timescale 1ns/10ps
`default_nettype none
module swl_trig_source (
    input  wire logic core_clk,
    output var logic  extTrigIn
);
    initial extTrigIn = 1'b0;
    task automatic drive(input logic lvl, input int holdCyc);
        @(posedge core_clk);
        #1;
        extTrigIn = lvl;
        repeat (holdCyc) @(posedge core_clk);
        #1;
    endtask : drive
endmodule : swl_trig_source
`default_nettype wire

// *** verif/swl_seq_properties.sv ***
// Concurrent checks on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module swl_seq_properties
    import swl_pkg::*;
#(
    parameter int LIST_N = LIST_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire swl_pkg::swl_func_t funcReq,
    input wire logic funcReqValid,
    input wire swl_pkg::swl_mode_t sweepMode,
    input wire swl_pkg::swl_mode_t listMode,
    input wire logic shapeTriangle,
    input wire logic spacingLog,
    input wire logic rangeByCenter,
    input wire logic [FREQ_W-1:0] freqCenter,
    input wire logic [FREQ_W-1:0] freqSpan,
    input wire logic [DWELL_W-1:0] sweepDwell,
    input wire logic indexWrEn,
    input wire logic [$clog2(LIST_N)-1:0] indexWrVal,
    input wire logic listResetCmd,
    input wire swl_pkg::swl_func_t activeFunc,
    input wire logic [FREQ_W-1:0] curFreq,
    input wire logic [$clog2(LIST_N)-1:0] curIndex,
    input wire logic running,
    input wire logic [FREQ_W-1:0] effStart,
    input wire logic [FREQ_W-1:0] effStop
);
    logic [FREQ_W-1:0]  prevFreq_reg;
    logic [DWELL_W-1:0] hold_reg;
    logic               sawRun;
    logic               sawRun_reg;

    assign sawRun = activeFunc == SWL_FREQ_SWEEP && running
        && sweepMode == SWL_AUTO && !shapeTriangle && !spacingLog;

    // Hold count restarts when the frequency moves or a run begins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            prevFreq_reg <= '0;
            hold_reg <= '0;
            sawRun_reg <= 1'b0;
        end else begin
            prevFreq_reg <= curFreq;
            hold_reg <= (curFreq != prevFreq_reg || !sawRun_reg)
                ? '0 : hold_reg + 1'b1;
            sawRun_reg <= sawRun;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_func_select: assert property (
        funcReqValid |=> activeFunc == $past(funcReq))
        else $error("Requested function not made active");
    a_center_span: assert property (
        rangeByCenter |-> effStart == freqCenter - (freqSpan >> 1)
            && effStop == freqCenter + (freqSpan >> 1))
        else $error("Center and span range inconsistent");
    a_freq_bounds: assert property (
        activeFunc == SWL_FREQ_SWEEP && running
            |-> curFreq >= effStart && curFreq <= effStop)
        else $error("Sweep frequency outside range");
    a_step_dwell: assert property (
        sawRun && sawRun_reg && prevFreq_reg != '0
            && curFreq != prevFreq_reg |-> hold_reg == sweepDwell - 1)
        else $error("Sweep step held for wrong time");
    a_saw_wrap: assert property (
        sawRun && sawRun_reg && curFreq < prevFreq_reg |-> curFreq == effStart)
        else $error("Sawtooth did not restart at start");
    a_index_write: assert property (
        indexWrEn && activeFunc == SWL_LIST && listMode == SWL_STEP
            |=> curIndex == $past(indexWrVal))
        else $error("Index write not applied");
    a_list_reset: assert property (
        listResetCmd && activeFunc == SWL_LIST |=> curIndex == '0)
        else $error("List reset did not return to first entry");
    a_auto_restart: assert property (
        activeFunc == SWL_LIST && listMode == SWL_AUTO && $changed(listMode)
            |-> ##[1:2] curIndex == '0)
        else $error("Auto list did not restart at first entry");

    c_saw_wrap: cover property (sawRun && curFreq < prevFreq_reg);
    c_list_reset: cover property (listResetCmd && activeFunc == SWL_LIST);
    c_index_write: cover property (indexWrEn && listMode == SWL_STEP);
endmodule : swl_seq_properties
`default_nettype wire

// *** verif/test_sweep_and_list_sequencer.sv ***
// Self-checking bench for the sweep and list sequencer
`timescale 1ns/10ps
`default_nettype none
module test_sweep_and_list_sequencer;
    import swl_pkg::*;
    localparam int LN = 4;
    logic core_clk;
    logic reset = 1'b1;
    swl_func_t funcReq = SWL_OFF;
    swl_func_t activeFunc, lastFunc;
    swl_mode_t sweepMode = SWL_AUTO;
    swl_mode_t listMode = SWL_STEP;
    logic funcReqValid = 1'b0, shapeTriangle = 1'b0, retraceEn = 1'b0;
    logic spacingLog = 1'b0, rangeByCenter = 1'b0, dwellFromList = 1'b0;
    logic entryWrEn = 1'b0, indexWrEn = 1'b0, sweepResetCmd = 1'b0;
    logic listResetCmd = 1'b0, executeCmd = 1'b0, trigSlopeFalling = 1'b0;
    logic extTrigIn, running;
    logic [FREQ_W-1:0] freqStart = 48'h64, freqStop = 48'h82;
    logic [FREQ_W-1:0] freqCenter = 48'h1000, freqSpan = 48'h100;
    logic [FREQ_W-1:0] freqStepLin = 48'hA, entryWrFreq = 48'h0;
    logic [FREQ_W-1:0] curFreq, effStart, effStop;
    logic [LOG_FRAC_W-1:0] freqStepLogFrac = 16'h0;
    logic signed [LEVEL_W-1:0] levelStart = 16'hFFEC, levelStop = 16'hA;
    logic [LEVEL_W-1:0] levelStepDb = 16'hA, entryWrLevel = 16'h0, curLevel;
    logic [DWELL_W-1:0] sweepDwell = 32'h3, globalDwell = 32'h3;
    logic [DWELL_W-1:0] entryWrDwell = 32'h2;
    logic [1:0] entryWrIdx = 2'h0, indexWrVal = 2'h0, curIndex, lastIdx;
    logic [63:0] v, lastV, tblF [LN], tblL [LN], tblD [LN];
    logic [31:0] rs = 32'hA2D32A08;
    longint mStart = 100, mStop = 130, mStep = 10, e;
    int errTotal = 0, totalChecks = 0, held = 0;
    bit mFresh = 1, armed = 0;

    swl_sequencer #(.LIST_N(LN)) dut_u (.core_clk, .reset, .funcReq,
        .funcReqValid, .sweepMode, .listMode, .shapeTriangle, .retraceEn,
        .spacingLog, .rangeByCenter, .freqStart, .freqStop, .freqCenter,
        .freqSpan, .freqStepLin, .freqStepLogFrac, .levelStart, .levelStop,
        .levelStepDb, .sweepDwell, .dwellFromList, .globalDwell, .entryWrEn,
        .entryWrIdx, .entryWrFreq, .entryWrLevel, .entryWrDwell, .indexWrEn,
        .indexWrVal, .sweepResetCmd, .listResetCmd, .executeCmd, .extTrigIn,
        .trigSlopeFalling, .activeFunc, .curFreq, .curLevel, .curIndex,
        .running, .effStart, .effStop);
    swl_trig_source trig_u (.core_clk, .extTrigIn);

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic tick(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask : pulse
    task automatic sel(input swl_func_t f);
        funcReq = f;
        mFresh = 1;
        pulse(funcReqValid);
    endtask : sel
    task automatic summarize();
        $display("checks=%0d errors=%0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        errTotal++;
        summarize();
    end

    // Model of the sweep and list outputs: sweep value checked on each change, list entries every cycle while running
    always @(posedge core_clk) begin
        #2;
        v = (activeFunc == SWL_LEVEL_SWEEP) ? 64'($signed(curLevel)) : 64'(curFreq);
        if (activeFunc inside {SWL_FREQ_SWEEP, SWL_LEVEL_SWEEP}
            && activeFunc == lastFunc && v !== lastV) begin
            // Log spacing adds a fraction of the present value
            e = $signed(lastV) + (spacingLog
                ? $signed((lastV * freqStepLogFrac) >> 16) : mStep);
            if (mFresh || e > mStop) e = mStart;
            chk(v, e);
            mFresh = 0;
        end else if (activeFunc inside {SWL_FREQ_SWEEP, SWL_LEVEL_SWEEP}
            && activeFunc != lastFunc) begin
            chk(v, mStart);
            mFresh = 0;
        end
        lastV = v;
        lastFunc = activeFunc;
        if (activeFunc == SWL_LIST && running === 1'b1) begin
            chk(curFreq, tblF[curIndex]);
            chk(curLevel, tblL[curIndex]);
        end
        if (activeFunc == SWL_LIST && listMode == SWL_AUTO) begin
            if (curIndex !== lastIdx) begin
                if (armed)
                    chk(held, dwellFromList ? tblD[lastIdx] : globalDwell);
                armed = 1;
                held = 0;
            end
            held++;
        end else begin
            armed = 0;
        end
        lastIdx = curIndex;
    end

    initial begin
        repeat (6) @(posedge core_clk);
        #1;
        reset = 1'b0;
        tick();
        sel(SWL_FREQ_SWEEP);
        tick();
        chk(activeFunc, SWL_FREQ_SWEEP);
        tick(36);
        sweepMode = SWL_SINGLE;
        tick(16);
        mFresh = 1;
        pulse(sweepResetCmd);
        pulse(executeCmd);
        tick(20);
        chk(curFreq, freqStop);
        spacingLog = 1'b1;
        freqStepLogFrac = 16'h2000;
        pulse(executeCmd);
        tick(20);
        // 100, 112, 126; the next step would pass the stop value
        chk(curFreq, 48'h7E);
        spacingLog = 1'b0;
        mStart = -20;
        mStop = 10;
        sweepDwell = 32'h2;
        sweepMode = SWL_AUTO;
        sel(SWL_LEVEL_SWEEP);
        tick(10);
        rs = xs(rs);
        freqCenter = {16'h1, rs};
        rangeByCenter = 1'b1;
        tick();
        chk(effStart, freqCenter - (freqSpan >> 1));
        chk(effStop, freqCenter + (freqSpan >> 1));
        rangeByCenter = 1'b0;
        tick(14);
        for (int i = 0; i < LN; i++) begin
            rs = xs(rs);
            entryWrIdx = 2'(i);
            entryWrFreq = {16'h0, rs};
            entryWrLevel = rs[15:0];
            entryWrDwell = 32'(rs[1:0]) + 32'h2;
            tblF[i] = 64'(entryWrFreq);
            tblL[i] = 64'(entryWrLevel);
            tblD[i] = 64'(entryWrDwell);
            pulse(entryWrEn);
            tick();
        end
        listMode = SWL_AUTO;
        sel(SWL_LIST);
        tick();
        chk(activeFunc, SWL_LIST);
        tick(30);
        listMode = SWL_STEP;
        tick(2);
        indexWrVal = 2'h3;
        pulse(indexWrEn);
        tick();
        chk(curIndex, 2'h3);
        trig_u.drive(1'b1, 6);
        chk(curIndex, 2'h0);
        trigSlopeFalling = 1'b1;
        tick(4);
        trig_u.drive(1'b0, 6);
        chk(curIndex, 2'h1);
        trig_u.drive(1'b1, 6);
        pulse(executeCmd);
        tick();
        chk(curIndex, 2'h1);
        pulse(indexWrEn);
        pulse(listResetCmd);
        tick();
        chk(curIndex, 2'h0);
        listMode = SWL_SINGLE;
        pulse(executeCmd);
        tick(2);
        chk(running, 1'b1);
        tick(20);
        chk(running, 1'b0);
        dwellFromList = 1'b1;
        listMode = SWL_AUTO;
        tick(40);
        summarize();
    end
endmodule : test_sweep_and_list_sequencer

bind swl_sequencer swl_seq_properties #(.LIST_N(LIST_N)) prop_u (.core_clk,
    .reset, .funcReq, .funcReqValid, .sweepMode, .listMode, .shapeTriangle,
    .spacingLog, .rangeByCenter, .freqCenter, .freqSpan, .sweepDwell,
    .indexWrEn, .indexWrVal, .listResetCmd, .activeFunc, .curFreq, .curIndex,
    .running, .effStart, .effStop);
`default_nettype wire
